// >>> inc/lsled_pkg.sv
// lsled_pkg.sv: constants and types for the lock status indicator sequencer
package lsled_pkg;

  // system clock rate, hz
  localparam int unsigned CLK_HZ        = 40_000_000;

  // start-up red interval, seconds
  localparam int unsigned STARTUP_S     = 10;
  localparam int unsigned STARTUP_CYC   = STARTUP_S * CLK_HZ;

  // slow flash 0.4 hz: period 2500 ms, half period 1250 ms
  localparam int unsigned SLOW_PER_MS   = 2500;
  localparam int unsigned SLOW_HALF_CYC = (SLOW_PER_MS / 2) * (CLK_HZ / 1000);

  // fast flash 6 hz: half period 1/12 s
  localparam int unsigned FAST_HZ       = 6;
  localparam int unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_HZ);

  // one-second pulse on time, ms
  localparam int unsigned PULSE_ON_MS   = 100;
  localparam int unsigned PULSE_ON_CYC  = PULSE_ON_MS * (CLK_HZ / 1000);

  // divider counter width, covers 400e6
  localparam int unsigned CNT_W         = 29;

  // sequencer stages, one-hot
  typedef enum logic [4:0] {
    LSLED_ST_START  = 5'h01,
    LSLED_ST_SEARCH = 5'h02,
    LSLED_ST_DETECT = 5'h04,
    LSLED_ST_DECODE = 5'h08,
    LSLED_ST_SYNC   = 5'h10
  } lsled_stage_t;

endpackage : lsled_pkg

// >>> hdl/lsled_sync.sv
// lsled_sync.sv: two-flop synchroniser for status inputs
`timescale 1ns/1ps
`default_nettype none

module lsled_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // state: first and second stage
  typedef struct packed {
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
  } lsled_sync_t;

  lsled_sync_t st_r;   // registered state
  lsled_sync_t st_nxt; // next state

  // shift chain; only the second stage is read outside
  always_comb begin
    st_nxt      = st_r;
    st_nxt.s1_r = d;
    st_nxt.s2_r = st_r.s1_r;
  end

  // register, synchronous active-low reset
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2_r;

endmodule : lsled_sync
`default_nettype wire

// >>> hdl/lsled_seq.sv
// lsled_seq.sv: red/green status indicator sequencer for the timing receiver
`timescale 1ns/1ps
`default_nettype none

module lsled_seq #(
  parameter int unsigned STARTUP_CYC_P   = lsled_pkg::STARTUP_CYC,
  parameter int unsigned SLOW_HALF_CYC_P = lsled_pkg::SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF_CYC_P = lsled_pkg::FAST_HALF_CYC,
  parameter int unsigned PULSE_ON_CYC_P  = lsled_pkg::PULSE_ON_CYC
) (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic sig_detect,   // engine: signal detected
  input  wire logic sig_locked,   // engine: locked, decoding
  input  wire logic time_valid,   // engine: timing fully decoded
  input  wire logic sec_tick,     // engine: utc second tick pulse
  input  wire logic quality_mode, // select signal-quality indication
  output logic      led_red,
  output logic      led_green
);

  localparam int unsigned CW = lsled_pkg::CNT_W;

  // divider limits sized to the counter
  localparam logic [CW-1:0] START_LIM = CW'(STARTUP_CYC_P - 1);
  localparam logic [CW-1:0] SLOW_LIM  = CW'(SLOW_HALF_CYC_P - 1);
  localparam logic [CW-1:0] FAST_LIM  = CW'(FAST_HALF_CYC_P - 1);
  localparam logic [CW-1:0] PULSE_LIM = CW'(PULSE_ON_CYC_P - 1);

  // engine status arrives from another logic island: resynchronise
  logic [4:0] in_s; // synchronised {mode, tick, valid, lock, detect}

  lsled_sync #(
    .W (5)
  ) u_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .d      ({quality_mode, sec_tick, time_valid, sig_locked, sig_detect}),
    .q      (in_s)
  );

  logic det_s;   // detect, synchronised
  logic lock_s;  // lock, synchronised
  logic valid_s; // decode done, synchronised
  logic tick_s;  // second tick level, synchronised
  logic qual_s;  // quality mode, synchronised

  assign det_s   = in_s[0];
  assign lock_s  = in_s[1];
  assign valid_s = in_s[2];
  assign tick_s  = in_s[3];
  assign qual_s  = in_s[4];

  // whole state of the sequencer
  typedef struct packed {
    lsled_pkg::lsled_stage_t stage_r; // acquisition stage
    logic [CW-1:0]           cnt_r;   // shared divider counter
    logic                    blink_r; // flash phase
    logic                    tick_d_r;// delayed tick for edge detect
    logic                    red_r;   // red output flop
    logic                    green_r; // green output flop
  } lsled_state_t;

  lsled_state_t st_r;   // registered state
  lsled_state_t st_nxt; // next state

  // counter wrap test used by several stages
  function automatic logic at_lim(input logic [CW-1:0] c, input logic [CW-1:0] lim);
    at_lim = (c >= lim);
  endfunction : at_lim

  logic tick_rise; // one-cycle utc second edge
  assign tick_rise = tick_s & ~st_r.tick_d_r;

  // stage sequencing, divider and indicator drive
  always_comb begin
    st_nxt          = st_r;
    st_nxt.tick_d_r = tick_s;
    unique case (st_r.stage_r)
      lsled_pkg::LSLED_ST_START: begin
        // hold red through the start-up interval
        if (at_lim(st_r.cnt_r, START_LIM)) begin
          st_nxt.stage_r = lsled_pkg::LSLED_ST_SEARCH;
          st_nxt.cnt_r   = '0;
        end else begin
          st_nxt.cnt_r = st_r.cnt_r + CW'(1);
        end
      end
      lsled_pkg::LSLED_ST_SEARCH: begin
        st_nxt.cnt_r   = '0;
        st_nxt.blink_r = 1'b1;
        if (det_s) begin
          st_nxt.stage_r = lsled_pkg::LSLED_ST_DETECT;
        end
      end
      lsled_pkg::LSLED_ST_DETECT: begin
        // slow flash; drop back if detection lost
        if (!det_s) begin
          st_nxt.stage_r = lsled_pkg::LSLED_ST_SEARCH;
          st_nxt.cnt_r   = '0;
        end else if (lock_s) begin
          st_nxt.stage_r = lsled_pkg::LSLED_ST_DECODE;
          st_nxt.cnt_r   = '0;
          st_nxt.blink_r = 1'b1;
        end else if (at_lim(st_r.cnt_r, SLOW_LIM)) begin
          st_nxt.cnt_r   = '0;
          st_nxt.blink_r = ~st_r.blink_r;
        end else begin
          st_nxt.cnt_r = st_r.cnt_r + CW'(1);
        end
      end
      lsled_pkg::LSLED_ST_DECODE: begin
        // fast flash until decode done; lock loss steps back
        if (!lock_s) begin
          st_nxt.stage_r = lsled_pkg::LSLED_ST_DETECT;
          st_nxt.cnt_r   = '0;
        end else if (valid_s) begin
          st_nxt.stage_r = lsled_pkg::LSLED_ST_SYNC;
          st_nxt.cnt_r   = '0;
          st_nxt.blink_r = 1'b0;
        end else if (at_lim(st_r.cnt_r, FAST_LIM)) begin
          st_nxt.cnt_r   = '0;
          st_nxt.blink_r = ~st_r.blink_r;
        end else begin
          st_nxt.cnt_r = st_r.cnt_r + CW'(1);
        end
      end
      lsled_pkg::LSLED_ST_SYNC: begin
        // pulse starts on the second edge, lasts a short on time
        if (!lock_s || !valid_s) begin
          st_nxt.stage_r = lsled_pkg::LSLED_ST_DECODE;
          st_nxt.cnt_r   = '0;
          st_nxt.blink_r = 1'b1;
        end else if (tick_rise) begin
          st_nxt.blink_r = 1'b1;
          st_nxt.cnt_r   = '0;
        end else if (st_r.blink_r) begin
          if (at_lim(st_r.cnt_r, PULSE_LIM)) begin
            st_nxt.blink_r = 1'b0;
          end else begin
            st_nxt.cnt_r = st_r.cnt_r + CW'(1);
          end
        end
      end
      default: begin
        // illegal code: restart the sequence
        st_nxt.stage_r = lsled_pkg::LSLED_ST_START;
        st_nxt.cnt_r   = '0;
      end
    endcase
    // indicator drive; quality mode overrides after start-up
    if (st_nxt.stage_r == lsled_pkg::LSLED_ST_START) begin
      st_nxt.red_r   = 1'b1;
      st_nxt.green_r = 1'b0;
    end else if (qual_s) begin
      st_nxt.red_r   = ~lock_s;
      st_nxt.green_r = lock_s;
    end else begin
      st_nxt.red_r   = 1'b0;
      st_nxt.green_r = (st_nxt.stage_r == lsled_pkg::LSLED_ST_SEARCH) | st_nxt.blink_r;
    end
  end

  // state register, synchronous active-low reset
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_r         <= '0;
      st_r.stage_r <= lsled_pkg::LSLED_ST_START;
      st_r.red_r   <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign led_red   = st_r.red_r;
  assign led_green = st_r.green_r;

  // red holds for the whole start-up interval
  start_red_a: assert property (@(posedge mclk) disable iff (!resetn)
    st_r.stage_r == lsled_pkg::LSLED_ST_START |-> led_red && !led_green)
    else $error("red not lit during start-up");

  // searching shows steady green outside quality mode
  search_green_a: assert property (@(posedge mclk) disable iff (!resetn)
    st_r.stage_r == lsled_pkg::LSLED_ST_SEARCH && !$past(qual_s) |-> led_green)
    else $error("green not steady while searching");

  // leaving search needs detection
  detect_enter_a: assert property (@(posedge mclk) disable iff (!resetn)
    $past(st_r.stage_r) == lsled_pkg::LSLED_ST_SEARCH
      && st_r.stage_r == lsled_pkg::LSLED_ST_DETECT |-> $past(det_s))
    else $error("detect stage without detection");

  // fast flash toggles only at its half period
  fast_toggle_a: assert property (@(posedge mclk) disable iff (!resetn)
    st_r.stage_r == lsled_pkg::LSLED_ST_DECODE && $past(st_r.stage_r)
      == lsled_pkg::LSLED_ST_DECODE && $changed(st_r.blink_r)
      |-> $past(st_r.cnt_r) == FAST_LIM)
    else $error("fast flash toggled off schedule");

  // second edge starts the green pulse
  sec_pulse_a: assert property (@(posedge mclk) disable iff (!resetn)
    st_r.stage_r == lsled_pkg::LSLED_ST_SYNC && tick_rise && lock_s && valid_s
      |=> st_r.blink_r)
    else $error("second tick did not start pulse");

  // quality mode mirrors lock
  quality_mode_a: assert property (@(posedge mclk) disable iff (!resetn)
    st_nxt.stage_r != lsled_pkg::LSLED_ST_START && qual_s
      |=> led_green == $past(lock_s) && led_red == !$past(lock_s))
    else $error("quality mode does not show lock");

  // lock loss drops decode back to detect
  lock_loss_a: assert property (@(posedge mclk) disable iff (!resetn)
    st_r.stage_r == lsled_pkg::LSLED_ST_DECODE && !lock_s
      |=> st_r.stage_r == lsled_pkg::LSLED_ST_DETECT)
    else $error("no fallback on lock loss");

  // detection loss drops back to search
  detect_loss_a: assert property (@(posedge mclk) disable iff (!resetn)
    st_r.stage_r == lsled_pkg::LSLED_ST_DETECT && !det_s
      |=> st_r.stage_r == lsled_pkg::LSLED_ST_SEARCH)
    else $error("no fallback on detection loss");

  reach_sync_c:   cover property (@(posedge mclk) st_r.stage_r == lsled_pkg::LSLED_ST_SYNC);
  reach_decode_c: cover property (@(posedge mclk) st_r.stage_r == lsled_pkg::LSLED_ST_DECODE);
  quality_c:      cover property (@(posedge mclk) qual_s && led_green);
  // slow flash actually toggling while a signal is detected
  detect_flash_c: cover property (@(posedge mclk)
    st_r.stage_r == lsled_pkg::LSLED_ST_DETECT && $changed(st_r.blink_r));

endmodule : lsled_seq
`default_nettype wire

// >>> dv/tb.sv
// tb.sv: self-checking bench for the lock status indicator sequencer
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic mclk;          // 40 mhz system clock
  logic resetn;        // synchronous reset, active low
  logic sig_detect;    // engine: signal detected
  logic sig_locked;    // engine: locked
  logic time_valid;    // engine: timing decoded
  logic sec_tick;      // utc second tick
  logic quality_mode;  // quality indication select
  logic led_red;       // red indicator seen
  logic led_green;     // green indicator seen
  int   bad_count;     // mismatches
  int   compares;      // comparisons made

  // shortened counts keep the run brief; every expectation follows them
  localparam int unsigned SU = 100;
  localparam int unsigned SH = 20;
  localparam int unsigned FH = 5;
  localparam int unsigned PO = 3;

  lsled_seq #(.STARTUP_CYC_P(SU), .SLOW_HALF_CYC_P(SH), .FAST_HALF_CYC_P(FH),
              .PULSE_ON_CYC_P(PO)) uut (
    .mclk(mclk), .resetn(resetn), .sig_detect(sig_detect), .sig_locked(sig_locked),
    .time_valid(time_valid), .sec_tick(sec_tick), .quality_mode(quality_mode),
    .led_red(led_red), .led_green(led_green));

  // free-running clock, 25 ns period
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // inputs move at the falling edge, away from the sampling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  task automatic chk(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  // a range, since a flash window may catch one edge more or less
  task automatic chk_rng(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%0h exp=%0h..%0h", $time, got, lo, hi);
    end
  endtask : chk_rng

  // counts green changes and green-on cycles over n cycles
  task automatic watch(input int n, output int tg, output int hi);
    logic prev;
    tg = 0;
    hi = 0;
    prev = led_green;
    repeat (n) begin
      @(negedge mclk);
      if (led_green !== prev) tg++;
      if (led_green === 1'b1) hi++;
      prev = led_green;
    end
  endtask : watch

  task automatic t_startup();
    int tg, hi;
    cyc(SU - 12);
    watch(8, tg, hi);
    chk(led_red, 1'b1);
    chk_rng(hi, 0, 0);
    cyc(15);
    watch(2 * SH, tg, hi);
    chk_rng(hi, 2 * SH, 2 * SH);
    chk(led_red, 1'b0);
    $display("test startup done");
  endtask : t_startup

  task automatic t_detect();
    int tg, hi;
    sig_detect = 1'b1;
    cyc(6);
    watch(3 * SH, tg, hi);
    chk_rng(tg, 2, 3);
    chk_rng(hi, SH - 6, 2 * SH);
    $display("test detect done");
  endtask : t_detect

  task automatic t_decode();
    int tg, hi;
    sig_locked = 1'b1;
    cyc(6);
    watch(8 * FH, tg, hi);
    chk_rng(tg, 7, 8);
    $display("test decode done");
  endtask : t_decode

  task automatic t_sync();
    int tg, hi;
    time_valid = 1'b1;
    cyc(6);
    watch(10, tg, hi);
    chk_rng(hi, 0, 0);
    repeat (2) begin
      sec_tick = 1'b1;
      cyc(2);
      sec_tick = 1'b0;
      watch(10, tg, hi);
      chk_rng(hi, PO, PO);
      watch(12, tg, hi);
      chk_rng(hi, 0, 0);
    end
    $display("test sync done");
  endtask : t_sync

  // each loss steps back one stage
  task automatic t_loss();
    int tg, hi;
    time_valid = 1'b0;
    cyc(6);
    watch(8 * FH, tg, hi);
    chk_rng(tg, 7, 8);
    sig_locked = 1'b0;
    cyc(6);
    watch(3 * SH, tg, hi);
    chk_rng(tg, 2, 3);
    sig_detect = 1'b0;
    cyc(6);
    watch(SH, tg, hi);
    chk_rng(hi, SH, SH);
    $display("test loss done");
  endtask : t_loss

  task automatic t_quality();
    quality_mode = 1'b1;
    sig_detect = 1'b1;
    sig_locked = 1'b1;
    cyc(6);
    chk(led_green, 1'b1);
    chk(led_red, 1'b0);
    sig_locked = 1'b0;
    cyc(6);
    chk(led_green, 1'b0);
    chk(led_red, 1'b1);
    $display("test quality done");
  endtask : t_quality

  task automatic end_sim();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  // main sequence: reset three cycles, then each scenario in turn
  initial begin
    resetn = 1'b0;
    sig_detect = 1'b0;
    sig_locked = 1'b0;
    time_valid = 1'b0;
    sec_tick = 1'b0;
    quality_mode = 1'b0;
    bad_count = 0;
    compares = 0;
    cyc(3);
    resetn = 1'b1;
    t_startup();
    t_detect();
    t_decode();
    t_sync();
    t_loss();
    t_quality();
    end_sim();
  end
endmodule : tb

`default_nettype wire
